/* logic/sks_pkg.sv */
// Purpose : shared types and constants for the skip / or execution unit
// Assumes : 16-bit instruction words, 8-bit data, 14-bit data addresses
// Notes   : every field position and count used by the unit lives here
`default_nettype none

package sks_pkg;

	// ****************************************************************
	// clock and phase timing
	// ****************************************************************
	localparam int          CLK_PERIOD_NS   = 50;         // mclk period
	localparam int          PHASES_PER_CYC  = 4;          // quarter phases per instruction cycle
	localparam int          CYCLE_NS        = CLK_PERIOD_NS * PHASES_PER_CYC;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int          DATA_W          = 8;          // data path width
	localparam int          ADDR_W          = 14;         // data memory address width
	localparam int          BANK_W          = 6;          // bank select register width
	localparam int          WORD_W          = 16;         // instruction word width

	// ****************************************************************
	// opcode field positions and codes
	// ****************************************************************
	localparam int          OPC6_HI         = 15;         // byte-op opcode field top
	localparam int          OPC6_LO         = 10;         // byte-op opcode field bottom
	localparam int          OPC8_LO         = 8;          // literal-op opcode field bottom
	localparam int          DEST_BIT        = 9;          // d bit
	localparam int          ACC_BIT         = 8;          // a bit
	localparam int          FILE_LO         = 0;          // f / k field bottom
	localparam logic [5:0]  OPC_INC_SKIP    = 6'h12;      // 0100 10da
	localparam logic [5:0]  OPC_OR_FILE     = 6'h04;      // 0001 00da
	localparam logic [7:0]  OPC_OR_LIT      = 8'h09;      // 0000 1001

	// ****************************************************************
	// addressing constants
	// ****************************************************************
	localparam logic [7:0]  IDX_MAX_F       = 8'h5f;      // indexed mode when f <= this
	localparam logic [7:0]  ACC_SPLIT_F     = 8'h60;      // lower access bank below this
	localparam logic [5:0]  ACC_LO_BANK     = 6'h00;      // bank of lower access half
	localparam logic [5:0]  ACC_HI_BANK     = 6'h3f;      // bank of upper access half

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0]  W_RESET         = 8'h00;
	localparam logic [1:0]  NOP_RESET       = 2'h0;
	localparam logic [1:0]  WORDS_ONE       = 2'h1;       // one-word follower

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		SKS_Q1,
		SKS_Q2,
		SKS_Q3,
		SKS_Q4
	} sks_phase_t;

	typedef enum logic [1:0] {
		SKS_OP_NONE,
		SKS_OP_INC_SKIP,
		SKS_OP_OR_LIT,
		SKS_OP_OR_FILE
	} sks_op_t;

	// decoded instruction carrier
	typedef struct packed {
		sks_op_t             op;
		logic                dest_file;
		logic                acc_bank;
		logic [DATA_W-1:0]   fk;
	} sks_instr_t;

	// file register port request carrier
	typedef struct packed {
		logic                rd_en;
		logic                wr_en;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wr_data;
	} sks_file_req_t;

	// architectural status carrier
	typedef struct packed {
		logic [DATA_W-1:0]   w;
		logic                n;
		logic                z;
	} sks_arch_t;

	// split an opcode word into its operation and fields
	function automatic sks_instr_t sks_decode(input logic [WORD_W-1:0] word);
		sks_instr_t d;
		d           = '0;
		d.dest_file = word[DEST_BIT];
		d.acc_bank  = word[ACC_BIT];
		d.fk        = word[FILE_LO +: DATA_W];
		if (word[OPC6_HI:OPC6_LO] == OPC_INC_SKIP) begin
			d.op = SKS_OP_INC_SKIP;
		end else if (word[OPC6_HI:OPC6_LO] == OPC_OR_FILE) begin
			d.op = SKS_OP_OR_FILE;
		end else if (word[OPC6_HI:OPC8_LO] == OPC_OR_LIT) begin
			d.op = SKS_OP_OR_LIT;
		end else begin
			d.op = SKS_OP_NONE;
		end
		return d;
	endfunction

	// true when the operation reads a file register
	function automatic logic sks_reads_file(input sks_op_t op);
		return (op == SKS_OP_INC_SKIP) || (op == SKS_OP_OR_FILE);
	endfunction

endpackage

`default_nettype wire

/* logic/sks_alu.sv */
// Purpose : data path of the unit: increment or inclusive or
// Assumes : operands are stable during the process phase
// Notes   : purely combinational
`default_nettype none
`timescale 1ns/1ps

module sks_alu (
	// operation and operands
	input  wire sks_pkg::sks_op_t             op_in,
	input  wire logic [sks_pkg::DATA_W-1:0]   operand_in,
	input  wire logic [sks_pkg::DATA_W-1:0]   w_in,
	// results
	output logic [sks_pkg::DATA_W-1:0]        result_out,
	output logic                              zero_out,
	output logic                              neg_out
);

	// ****************************************************************
	// arithmetic
	// ****************************************************************
	// increment wraps modulo 256; a wrap to zero is what blocks the skip
	always_comb begin
		unique case (op_in)
			sks_pkg::SKS_OP_INC_SKIP: result_out = operand_in + 8'h01;
			sks_pkg::SKS_OP_OR_LIT:   result_out = operand_in | w_in;
			sks_pkg::SKS_OP_OR_FILE:  result_out = operand_in | w_in;
			sks_pkg::SKS_OP_NONE:     result_out = w_in;
		endcase
	end

	assign zero_out = (result_out == 8'h00);
	assign neg_out  = result_out[sks_pkg::DATA_W-1];

endmodule

`default_nettype wire

/* logic/sks_addr.sv */
// Purpose : forms the data address of a byte operation
// Assumes : bank select and index base are stable while decoding
// Notes   : combinational; indexed mode only with access bit clear
`default_nettype none
`timescale 1ns/1ps

module sks_addr (
	// instruction fields
	input  wire logic [sks_pkg::DATA_W-1:0]   f_in,
	input  wire logic                         acc_bank_in,
	// core state
	input  wire logic                         ext_set_en_in,
	input  wire logic [sks_pkg::BANK_W-1:0]   bank_select_register_in,
	input  wire logic [sks_pkg::ADDR_W-1:0]   index_base_in,
	// result
	output logic [sks_pkg::ADDR_W-1:0]        addr_out,
	output logic                              indexed_out
);

	// ****************************************************************
	// address selection
	// ****************************************************************
	always_comb begin
		indexed_out = !acc_bank_in && ext_set_en_in && (f_in <= sks_pkg::IDX_MAX_F);
		if (indexed_out) begin
			// literal offset from the index base, wraps in the address space
			addr_out = index_base_in + {6'h00, f_in};
		end else if (acc_bank_in) begin
			addr_out = {bank_select_register_in, f_in};
		end else if (f_in < sks_pkg::ACC_SPLIT_F) begin
			addr_out = {sks_pkg::ACC_LO_BANK, f_in};
		end else begin
			addr_out = {sks_pkg::ACC_HI_BANK, f_in};
		end
	end

endmodule

`default_nettype wire

/* logic/sks_exec.sv */
// Purpose : executes increment-skip-if-nonzero, or-literal and or-file
// Assumes : file memory answers a read in the same mclk cycle
// Notes   : one instruction cycle is four mclk cycles (quarter phases)
`default_nettype none
`timescale 1ns/1ps

module sks_exec (
	// clock and reset
	input  wire logic                         mclk_in,
	input  wire logic                         rst_n_in,
	// instruction feed
	input  wire logic                         instr_valid_in,
	input  wire logic [sks_pkg::WORD_W-1:0]   instr_word_in,
	input  wire logic [1:0]                   next_words_in,
	output logic                              instr_ready_out,
	// addressing context
	input  wire logic                         ext_set_en_in,
	input  wire logic [sks_pkg::BANK_W-1:0]   bank_select_register_in,
	input  wire logic [sks_pkg::ADDR_W-1:0]   index_base_in,
	// file register port
	output sks_pkg::sks_file_req_t            file_req_out,
	input  wire logic [sks_pkg::DATA_W-1:0]   file_rd_data_in,
	// architectural state and status
	output sks_pkg::sks_arch_t                arch_out,
	output sks_pkg::sks_phase_t               phase_out,
	output logic                              nop_cycle_out,
	output logic                              skip_taken_out,
	output logic                              indexed_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		sks_pkg::sks_phase_t               phase;      // current quarter phase
		logic                              active;     // a real instruction is running
		sks_pkg::sks_instr_t               instr;      // decoded instruction
		logic [1:0]                        follow;     // words of the next instruction
		logic [sks_pkg::DATA_W-1:0]        operand;    // operand latched in q2
		logic [sks_pkg::DATA_W-1:0]        result;     // result latched in q3
		logic                              res_z;      // zero of result
		logic                              res_n;      // sign of result
		logic [1:0]                        nop_left;   // no-operation cycles pending
		logic                              in_nop;     // current cycle is a no-op cycle
		logic                              skip;       // one-cycle skip strobe
		logic                              indexed;    // last address was indexed
		sks_pkg::sks_file_req_t            req;        // file port request
		sks_pkg::sks_arch_t                arch;       // working register and flags
	} sks_state_t;

	sks_state_t                  st_r;        // registered state
	sks_state_t                  st_nxt;      // next state
	sks_pkg::sks_instr_t         dec;         // decode of the incoming word
	logic [sks_pkg::ADDR_W-1:0]  addr_calc;   // address for the incoming word
	logic                        idx_calc;    // incoming word uses indexed mode
	logic [sks_pkg::DATA_W-1:0]  alu_res;     // data path result
	logic                        alu_z;       // data path zero
	logic                        alu_n;       // data path sign
	logic                        accept;      // instruction taken this cycle

	// ****************************************************************
	// decode and helpers
	// ****************************************************************
	// decoding is done on the raw word so the address is ready by q2
	assign dec = sks_pkg::sks_decode(instr_word_in);

	sks_addr i_sks_addr (
		.f_in                    (dec.fk),
		.acc_bank_in             (dec.acc_bank),
		.ext_set_en_in           (ext_set_en_in),
		.bank_select_register_in (bank_select_register_in),
		.index_base_in (index_base_in),
		.addr_out      (addr_calc),
		.indexed_out   (idx_calc)
	);

	sks_alu i_sks_alu (
		.op_in      (st_r.instr.op),
		.operand_in (st_r.operand),
		.w_in       (st_r.arch.w),
		.result_out (alu_res),
		.zero_out   (alu_z),
		.neg_out    (alu_n)
	);

	// ready only at the start of a cycle that is not owed to a skip
	assign instr_ready_out = (st_r.phase == sks_pkg::SKS_Q1) && (st_r.nop_left == 2'h0);
	assign accept          = instr_ready_out && instr_valid_in;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt             = st_r;
		st_nxt.skip        = 1'b0;
		st_nxt.req.rd_en   = 1'b0;
		st_nxt.req.wr_en   = 1'b0;
		unique case (st_r.phase)
			sks_pkg::SKS_Q1: begin
				// decode quarter; the phase ring never stops
				st_nxt.phase  = sks_pkg::SKS_Q2;
				if (st_r.nop_left != 2'h0) begin
					// burn a whole cycle, no port activity at all
					st_nxt.active   = 1'b0;
					st_nxt.nop_left = st_r.nop_left - 2'h1;
				end else if (accept) begin
					st_nxt.active = (dec.op != sks_pkg::SKS_OP_NONE);
					st_nxt.instr  = dec;
					st_nxt.follow = next_words_in;
					if (sks_pkg::sks_reads_file(dec.op)) begin
						// read request stands through q2
						st_nxt.req.rd_en = 1'b1;
						st_nxt.req.addr  = addr_calc;
						st_nxt.indexed   = idx_calc;
					end
				end else begin
					st_nxt.active = 1'b0;
				end
			end
			sks_pkg::SKS_Q2: begin
				// operand quarter: file data or the literal
				st_nxt.phase = sks_pkg::SKS_Q3;
				if (st_r.active) begin
					if (st_r.instr.op == sks_pkg::SKS_OP_OR_LIT) begin
						st_nxt.operand = st_r.instr.fk;
					end else begin
						st_nxt.operand = file_rd_data_in;
					end
				end
			end
			sks_pkg::SKS_Q3: begin
				// process quarter: latch result, arm the write
				st_nxt.phase = sks_pkg::SKS_Q4;
				if (st_r.active) begin
					st_nxt.result = alu_res;
					st_nxt.res_z  = alu_z;
					st_nxt.res_n  = alu_n;
					// or-literal always lands in w; others follow the d bit
					if ((st_r.instr.op != sks_pkg::SKS_OP_OR_LIT) && st_r.instr.dest_file) begin
						st_nxt.req.wr_en   = 1'b1;
						st_nxt.req.wr_data = alu_res;
					end
				end
			end
			sks_pkg::SKS_Q4: begin
				// write quarter: commit w, flags and the skip decision
				st_nxt.phase = sks_pkg::SKS_Q1;
				if (st_r.active) begin
					if ((st_r.instr.op == sks_pkg::SKS_OP_OR_LIT) || !st_r.instr.dest_file) begin
						st_nxt.arch.w = st_r.result;
					end
					if (st_r.instr.op != sks_pkg::SKS_OP_INC_SKIP) begin
						// increment-skip leaves the status flags alone
						st_nxt.arch.n = st_r.res_n;
						st_nxt.arch.z = st_r.res_z;
					end else if (!st_r.res_z) begin
						// follower is already fetched; its words become no-op cycles
						st_nxt.skip = 1'b1;
						if (st_r.follow == 2'h0) begin
							// an unstated length is taken as one word
							st_nxt.nop_left = sks_pkg::WORDS_ONE;
						end else begin
							st_nxt.nop_left = st_r.follow;
						end
					end
				end
				// flag set as the dead cycle begins, so it never spills into the next q1
				st_nxt.in_nop = (st_nxt.nop_left != 2'h0);
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r          <= '0;
			st_r.phase    <= sks_pkg::SKS_Q1;
			st_r.nop_left <= sks_pkg::NOP_RESET;
			st_r.arch.w   <= sks_pkg::W_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign file_req_out   = st_r.req;
	assign arch_out       = st_r.arch;
	assign phase_out      = st_r.phase;
	assign nop_cycle_out  = st_r.in_nop;
	assign skip_taken_out = st_r.skip;
	assign indexed_out    = st_r.indexed;

endmodule

`default_nettype wire

/* sim/sks_exec_assertions.sv */
// Purpose : port-level checks for the skip / or execution unit
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound to every sks_exec instance below
`timescale 1ns/1ps
`default_nettype none

module sks_exec_assertions (
	// clock and reset
	input wire logic                        mclk_in,
	input wire logic                        rst_n_in,
	// instruction feed
	input wire logic                        instr_valid_in,
	input wire logic [sks_pkg::WORD_W-1:0]  instr_word_in,
	input wire logic [1:0]                  next_words_in,
	input wire logic                        instr_ready_out,
	// addressing context
	input wire logic                        ext_set_en_in,
	input wire logic [sks_pkg::BANK_W-1:0]  bank_select_register_in,
	input wire logic [sks_pkg::ADDR_W-1:0]  index_base_in,
	// file port and status
	input wire sks_pkg::sks_file_req_t      file_req_out,
	input wire logic [sks_pkg::DATA_W-1:0]  file_rd_data_in,
	input wire sks_pkg::sks_arch_t          arch_out,
	input wire sks_pkg::sks_phase_t         phase_out,
	input wire logic                        nop_cycle_out,
	input wire logic                        skip_taken_out,
	input wire logic                        indexed_out
);
	// ****************************************************************
	// take decode
	// ****************************************************************
	logic take, t_inc, t_lit, t_orf;  // accepted instruction by kind
	assign take  = phase_out == sks_pkg::SKS_Q1 && instr_ready_out && instr_valid_in;
	assign t_inc = take && instr_word_in[15:10] == sks_pkg::OPC_INC_SKIP;
	assign t_lit = take && instr_word_in[15:8] == sks_pkg::OPC_OR_LIT;
	assign t_orf = take && instr_word_in[15:10] == sks_pkg::OPC_OR_FILE;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	// ****************************************************************
	// properties
	// ****************************************************************
	sequence s_quiet4;  // literal op never touches the file port
		(!file_req_out.rd_en && !file_req_out.wr_en)[*4];
	endsequence
	sequence s_nop4;  // one full dead instruction cycle
		(nop_cycle_out && !instr_ready_out)[*4];
	endsequence
	property p_rd_q2; (t_inc || t_orf) |=> file_req_out.rd_en; endproperty
	property p_rd_phase; file_req_out.rd_en |-> phase_out == sks_pkg::SKS_Q2; endproperty
	property p_wr_phase; file_req_out.wr_en |-> phase_out == sks_pkg::SKS_Q4; endproperty
	property p_lit_quiet; t_lit |=> s_quiet4; endproperty
	property p_lit_res;
		t_lit |-> ##4 (arch_out.w == ($past(arch_out.w, 4) | $past(instr_word_in[7:0], 4))
			&& arch_out.z == (arch_out.w == 8'h00) && arch_out.n == arch_out.w[7]);
	endproperty
	property p_dest; t_orf |-> ##3 (file_req_out.wr_en == $past(instr_word_in[9], 3)); endproperty
	property p_bank;
		t_orf && instr_word_in[8] |=> file_req_out.addr ==
			{$past(bank_select_register_in), $past(instr_word_in[7:0])};
	endproperty
	property p_index;
		t_orf && !instr_word_in[8] && ext_set_en_in && instr_word_in[7:0] <= 8'h5f
			|=> file_req_out.addr == $past(index_base_in) + 14'($past(instr_word_in[7:0])) ##1 indexed_out;
	endproperty
	property p_skip; t_inc |-> ##4 (skip_taken_out == ($past(file_rd_data_in, 3) != 8'hff)); endproperty
	property p_nops; skip_taken_out |-> s_nop4; endproperty
	property p_nop_idle; nop_cycle_out |-> !file_req_out.rd_en && !file_req_out.wr_en; endproperty

	a_rd_q2:     assert property (p_rd_q2)     else $error("no read after take");
	a_rd_phase:  assert property (p_rd_phase)  else $error("read off phase two");
	a_wr_phase:  assert property (p_wr_phase)  else $error("write off phase four");
	a_lit_quiet: assert property (p_lit_quiet) else $error("literal op used file port");
	a_lit_res:   assert property (p_lit_res)   else $error("literal or result wrong");
	a_dest:      assert property (p_dest)      else $error("destination choice wrong");
	a_bank:      assert property (p_bank)      else $error("banked address wrong");
	a_index:     assert property (p_index)     else $error("indexed address wrong");
	a_skip:      assert property (p_skip)      else $error("skip decision wrong");
	a_nops:      assert property (p_nops)      else $error("dead cycle missing");
	a_nop_idle:  assert property (p_nop_idle)  else $error("dead cycle touched file");
endmodule

bind sks_exec sks_exec_assertions i_sks_exec_assertions (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
	.next_words_in(next_words_in), .instr_ready_out(instr_ready_out),
	.ext_set_en_in(ext_set_en_in), .bank_select_register_in(bank_select_register_in),
	.index_base_in(index_base_in),
	.file_req_out(file_req_out), .file_rd_data_in(file_rd_data_in), .arch_out(arch_out),
	.phase_out(phase_out), .nop_cycle_out(nop_cycle_out), .skip_taken_out(skip_taken_out),
	.indexed_out(indexed_out));
`default_nettype wire

/* sim/tb_top.sv */
// Purpose : self-checking bench for the skip / or execution unit
// Assumes : bench stands in for fetch and file memory
// Notes   : driver notes results in queues, monitors pop them
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ****************************************************************
	// stimulus and observation
	// ****************************************************************
	logic                 mclk_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0;
	logic [15:0]          instr_word_in = 16'h0000;
	logic [1:0]           next_words_in = 2'h1;
	logic                 ext_set_en_in = 1'b0;
	logic [5:0]           bank_select_register_in = 6'h00, b;
	logic [13:0]          index_base_in = 14'h0000, base;
	logic [7:0]           file_rd_data_in = 8'h00, f;
	logic                 instr_ready_out, nop_cycle_out, skip_taken_out, indexed_out;
	sks_pkg::sks_file_req_t file_req_out;
	sks_pkg::sks_arch_t   arch_out, m;  // m: expected working state
	sks_pkg::sks_phase_t  phase_out;
	int                   errors = 0, comparisons = 0, i, rnd;
	typedef struct packed { sks_pkg::sks_arch_t a; logic skip; logic [1:0] nw; } sks_note_t;
	typedef struct packed { logic [13:0] addr; logic [7:0] data; } sks_wr_t;
	sks_note_t            arch_q[$];  // one note per instruction
	sks_wr_t              wr_q[$];    // one note per file write

	sks_exec i_sks_exec (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
		.instr_word_in(instr_word_in), .next_words_in(next_words_in),
		.instr_ready_out(instr_ready_out), .ext_set_en_in(ext_set_en_in),
		.bank_select_register_in(bank_select_register_in),
		.index_base_in(index_base_in), .file_req_out(file_req_out),
		.file_rd_data_in(file_rd_data_in), .arch_out(arch_out), .phase_out(phase_out),
		.nop_cycle_out(nop_cycle_out), .skip_taken_out(skip_taken_out), .indexed_out(indexed_out));

	always #25 mclk_in = ~mclk_in;  // 20 MHz

	// ****************************************************************
	// compare tasks
	// ****************************************************************
	task automatic cmp_arch(input sks_pkg::sks_arch_t e, input sks_pkg::sks_arch_t s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("unexpected arch exp %h seen %h", e, s);
		end
	endtask
	task automatic cmp_wr(input sks_wr_t e, input sks_wr_t s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("unexpected file write exp %h seen %h", e, s);
		end
	endtask
	task automatic cmp_bit(input string nm, input logic e, input logic s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %b seen %b", nm, e, s);
		end
	endtask
	task automatic cmp_gap(input int e, input int s);
		comparisons++;
		if (s != e) begin
			errors++;
			$display("unexpected dead cycles exp %0d seen %0d", e, s);
		end
	endtask

	// ****************************************************************
	// driver: offer word, note results, hold until taken
	// ****************************************************************
	task automatic exec(input logic [15:0] wd, input logic [7:0] rd, input logic [1:0] nw,
		input logic [13:0] ad);
		sks_note_t nt;
		logic [7:0] res;
		int k;
		begin
			instr_word_in <= wd;
			next_words_in <= nw;
			file_rd_data_in <= rd;
			instr_valid_in <= 1'b1;
			nt = '0;
			nt.nw = nw;
			if (wd[15:10] == 6'h12) begin  // increment, flags untouched
				res = rd + 8'h01;
				nt.skip = res != 8'h00;
				wr_q.push_back({ad, res});
			end else if (wd[15:8] == 8'h09 || wd[15:10] == 6'h04) begin
				res = (wd[15:8] == 8'h09) ? (m.w | wd[7:0]) : (m.w | rd);
				if (wd[15:10] == 6'h04 && wd[9])
					wr_q.push_back({ad, res});
				m = '{w: (wd[15:10] == 6'h04 && wd[9]) ? m.w : res, n: res[7], z: res == 8'h00};
			end
			nt.a = m;
			arch_q.push_back(nt);
			k = 0;
			do begin
				@(negedge mclk_in);
				k++;
			end while (!(phase_out === sks_pkg::SKS_Q1 && instr_ready_out === 1'b1) && k < 60);
			if (k >= 60)
				errors++;
			// keep read data steady through the read phase
			repeat (3) @(posedge mclk_in);
		end
	endtask

	// ****************************************************************
	// monitors
	// ****************************************************************
	task automatic after_take();
		sks_note_t nt;
		int k;
		begin
			// results land at the edge ending q4; the skip pulse lasts one cycle
			repeat (3) @(posedge mclk_in);
			#1;
			if (arch_q.size() == 0) begin
				errors++;
			end else begin
				nt = arch_q.pop_front();
				cmp_arch(nt.a, arch_out);
				cmp_bit("skip", nt.skip, skip_taken_out);
				cmp_bit("nop", nt.skip, nop_cycle_out);
				k = 0;
				while (instr_ready_out !== 1'b1 && k < 20) begin
					@(posedge mclk_in);
					#1;
					k++;
				end
				cmp_gap(nt.skip ? 4 * ((nt.nw == 2'h0) ? 1 : int'(nt.nw)) : 0, k);
			end
		end
	endtask
	always @(posedge mclk_in) begin  // old values seen: race free
		if (phase_out === sks_pkg::SKS_Q1 && instr_ready_out === 1'b1 && instr_valid_in === 1'b1)
			fork
				after_take();
			join_none
	end
	always @(negedge mclk_in) begin
		if (file_req_out.wr_en === 1'b1) begin
			if (wr_q.size() == 0)
				errors++;
			else
				cmp_wr(wr_q.pop_front(), {file_req_out.addr, file_req_out.wr_data});
		end
	end

	// ****************************************************************
	// verdict and watchdog
	// ****************************************************************
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0 && wr_q.size() == 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(sks_pkg::CLK_PERIOD_NS * 5000);
		errors++;
		finish_test();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		rnd = $urandom(9636);
		m = '0;
		base = 14'($urandom);
		repeat (6) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		index_base_in <= base;
		exec(16'h0900, 8'h00, 2'h1, 14'h0000);
		exec(16'h0980, 8'h00, 2'h1, 14'h0000);
		for (i = 0; i < 4; i++)
			exec({8'h09, 8'($urandom)}, 8'($urandom), 2'h1, 14'h0000);
		$display("test or_literal done");
		for (i = 0; i < 4; i++) begin
			b = 6'($urandom);
			f = 8'($urandom);
			bank_select_register_in <= b;
			exec({6'h04, i[0], 1'b1, f}, 8'($urandom), 2'h1, {b, f});
		end
		$display("test or_file banked done");
		exec({8'h12, 8'h10}, 8'h21, 2'h1, 14'h0010);
		exec({8'h12, 8'h80}, 8'h42, 2'h1, 14'h3f80);
		ext_set_en_in <= 1'b1;
		exec({8'h12, 8'h5f}, 8'h0c, 2'h1, base + 14'h005f);
		exec({8'h12, 8'h60}, 8'h90, 2'h1, 14'h3f60);
		ext_set_en_in <= 1'b0;
		$display("test or_file access done");
		exec({8'h4a, 8'h20}, 8'hff, 2'h1, 14'h0020);
		for (i = 0; i < 4; i++)
			exec({8'h4a, 8'h20}, 8'($urandom % 255), 2'(i), 14'h0020);
		exec(16'hffff, 8'h00, 2'h1, 14'h0000);
		instr_valid_in <= 1'b0;
		$display("test skip and unknown done");
		repeat (20) @(posedge mclk_in);
		finish_test();
	end
endmodule
`default_nettype wire
